// file: deir_pkg.sv
// Shared constants for the event-input routing block of the data-movement controller.
`default_nettype none
package deir_pkg;
  // ---------------------------------------------------------------------------
  // Register byte addresses.
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_EDGE_POL = 32'h6000_0008;
  localparam logic [31:0] ADDR_EN_SET = 32'h6000_000C;
  localparam logic [31:0] ADDR_EN_CLR = 32'h6000_0010;
  localparam logic [31:0] ADDR_HP_SEL = 32'h6000_0014;
  localparam logic [31:0] ADDR_LP_SEL = 32'h6000_0018;
  localparam logic [31:0] ADDR_FLAGS = 32'h6000_001C;
  localparam logic [31:0] ADDR_LINE0 = 32'h6000_0034;
  localparam logic [31:0] ADDR_CBUF0 = 32'h6000_0040;
  localparam logic [31:0] ADDR_LINE1 = 32'h6000_0054;
  localparam logic [31:0] ADDR_CBUF1 = 32'h6000_0060;
  localparam logic [31:0] ADDR_LINE2 = 32'h6000_0074;
  localparam logic [31:0] ADDR_DONE0 = 32'h6000_0080;
  localparam logic [31:0] ADDR_LINE3 = 32'h6000_0094;
  localparam logic [31:0] ADDR_DONE1 = 32'h6000_00A0;
  localparam logic [31:0] ADDR_MUTE_SEL0 = 32'h6000_00C0;
  localparam logic [31:0] ADDR_MUTE_SEL1 = 32'h6000_00C4;
  localparam logic [31:0] ADDR_MUTE_SEL2 = 32'h6000_00C8;
  localparam logic [31:0] ADDR_WAIT_CTRL = 32'h6000_00CC;
  localparam logic [31:0] ADDR_IRQ_SEL = 32'h6000_00D0;

  // ---------------------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------------------
  localparam int WAIT_EN_BIT = 0;
  localparam int WAIT_POL_BIT = 1;
  localparam logic [2:0] MUTE_SEL_NONE = 3'h7;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int NUM_AUDIO = 3;
  localparam int NUM_PINS = 7;
  localparam int NUM_EVENTS = 32;

  // ---------------------------------------------------------------------------
  // Event numbers of each source.
  // ---------------------------------------------------------------------------
  localparam int EV_SW_LOW [4] = '{0, 10, 17, 23};
  localparam int EV_SW_HIGH [4] = '{1, 11, 18, 24};
  localparam int SW_HIGH_BASE = 16;
  localparam int EV_SW_EXTRA [2] = '{30, 31};
  localparam int SW_EXTRA_BASE = 20;
  localparam int EV_TIMER [4] = '{2, 3, 15, 16};
  localparam int EV_AUDIO_REQ_BASE = 4;
  localparam int EV_HOST = 12;
  localparam int EV_SPI_BASE = 13;
  localparam int EV_I2C_BASE = 19;
  localparam int EV_RESERVED = 25;
  localparam int EV_AUDIO_ERR_BASE = 26;
  localparam int EV_TIMER_OVF = 29;
endpackage
`default_nettype wire

// file: deir_if.sv
// Pin-level connection between the routing block and the sources that feed it.
`default_nettype none
interface deir_if;
  logic [3:0] timerRequest;      // Timer requests 0..3.
  logic [5:0] audioRequest;      // Audio tx0, rx0, tx1, rx1, tx2, rx2 requests.
  logic hostPortCpuEvent;        // Host-port CPU interrupt.
  logic [1:0] spiReceiveRequest; // SPI 0 and 1 receive requests.
  logic [3:0] i2cEvent;          // I2C 0 tx, 0 rx, 1 tx, 1 rx.
  logic [2:0] audioTxInt;        // Audio transmit interrupts per port.
  logic [2:0] audioRxInt;        // Audio receive interrupts per port.
  logic timerOverflowError;      // Timer overflow error.
  logic [6:0] ioPin;             // Asynchronous I/O pins usable as mute sources.
  logic memoryWaitInput;         // Asynchronous memory wait pin.
  logic nonmaskableInterruptLine; // Interrupt pulse towards the CPU.

  modport device (
    input timerRequest, audioRequest, hostPortCpuEvent, spiReceiveRequest, i2cEvent,
    input audioTxInt, audioRxInt, timerOverflowError, ioPin, memoryWaitInput,
    output nonmaskableInterruptLine
  );
  modport source (
    output timerRequest, audioRequest, hostPortCpuEvent, spiReceiveRequest, i2cEvent,
    output audioTxInt, audioRxInt, timerOverflowError, ioPin, memoryWaitInput,
    input nonmaskableInterruptLine
  );
endinterface
`default_nettype wire

// file: deir_source.sv
// Peripheral and external-pin end that drives the event sources of the routing block.
`default_nettype none
module deir_source (
  input wire logic ref_clk,
  input wire logic rst_n,
  deir_if.source link,
  input wire logic [3:0] timerRequestIn,
  input wire logic [5:0] audioRequestIn,
  input wire logic hostPortIn,
  input wire logic [1:0] spiReceiveIn,
  input wire logic [3:0] i2cEventIn,
  input wire logic [2:0] audioTxIntIn,
  input wire logic [2:0] audioRxIntIn,
  input wire logic timerOverflowIn,
  input wire logic [6:0] ioPinIn,
  input wire logic memoryWaitIn,
  output logic nmiSeen
);
  // ---------------------------------------------------------------------------
  // Source registers.
  // ---------------------------------------------------------------------------
  // Peripheral lines leave from flip-flops so the device sees clean levels.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      link.timerRequest <= 4'h0;
      link.audioRequest <= 6'h00;
      link.hostPortCpuEvent <= 1'b0;
      link.spiReceiveRequest <= 2'h0;
      link.i2cEvent <= 4'h0;
      link.audioTxInt <= 3'h0;
      link.audioRxInt <= 3'h0;
      link.timerOverflowError <= 1'b0;
    end
    else
    begin
      link.timerRequest <= timerRequestIn;
      link.audioRequest <= audioRequestIn;
      link.hostPortCpuEvent <= hostPortIn;
      link.spiReceiveRequest <= spiReceiveIn;
      link.i2cEvent <= i2cEventIn;
      link.audioTxInt <= audioTxIntIn;
      link.audioRxInt <= audioRxIntIn;
      link.timerOverflowError <= timerOverflowIn;
    end
  end

  // External pins pass straight through; the caller must hold the wait pin
  // high for two or more clocks and a mute pin pulse for two or more clocks.
  assign link.ioPin = ioPinIn;
  assign link.memoryWaitInput = memoryWaitIn;

  // The interrupt pulse is registered back to the user side.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      nmiSeen <= 1'b0;
    else
      nmiSeen <= link.nonmaskableInterruptLine;
  end
endmodule // deir_source
`default_nettype wire

// file: deir_device.sv
// Event-input routing, configuration registers and external interrupt paths.
//
// The Wishbone register port is this design's own decision.
`default_nettype none
module deir_device (
  input wire logic ref_clk,
  input wire logic rst_n,
  deir_if.device link,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic swTriggerWrite,
  input wire logic [31:0] swTriggerData,
  output logic [31:0] swTriggerValue,
  output logic [31:0] swEventStatus,
  output logic [31:0] highGroupPending,
  output logic [31:0] lowGroupPending,
  output logic cpuEventInterrupt,
  output logic waitPolarity
);
  // ---------------------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------------------
  logic [31:0] edgePol_reg;      // 1 captures rising, 0 captures falling.
  logic [31:0] enable_reg;       // Per-event enable.
  logic [31:0] hpSel_reg;        // High-priority group membership.
  logic [31:0] lpSel_reg;        // Low-priority group membership.
  logic [31:0] flags_reg;        // Captured event flags.
  logic [31:0] irqSel_reg;       // Events whose entry issues a CPU interrupt.
  logic [31:0] swTrig_reg;       // Software trigger register.
  logic [2:0] muteSel_reg [deir_pkg::NUM_AUDIO]; // Mute pin choice per port.
  logic waitEn_reg;              // Wait interrupt enable.
  logic waitPol_reg;             // Wait-state polarity, for the memory controller only.
  logic [31:0] line_reg;         // Registered event lines, read back as line state.
  logic [31:0] eventLine;        // Combined event lines this cycle.
  logic [31:0] flags_next;       // Next flag value.
  logic [31:0] rdData;           // Read mux output.
  logic [6:0] pinMeta_reg;       // First synchroniser stage of the I/O pins.
  logic [6:0] pinSync_reg;       // Second synchroniser stage of the I/O pins.
  logic waitMeta_reg;            // First synchroniser stage of the wait pin.
  logic waitSync_reg;            // Second synchroniser stage of the wait pin.
  logic waitPrev_reg;            // Previous synchronised wait level.
  logic nmi_reg;                 // Interrupt pulse register.
  logic [2:0] mutePin;           // Selected mute request input per port.
  logic wbReq;                   // A new bus access this cycle.
  logic wbWrite;                 // A new bus write this cycle.

  // ---------------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------------
  // Two stages on every asynchronous pin; only the second stage is read.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pinMeta_reg <= 7'h00;
      pinSync_reg <= 7'h00;
      waitMeta_reg <= 1'b0;
      waitSync_reg <= 1'b0;
    end
    else
    begin
      pinMeta_reg <= link.ioPin;
      pinSync_reg <= pinMeta_reg;
      waitMeta_reg <= link.memoryWaitInput;
      waitSync_reg <= waitMeta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Mute source multiplexers and event line map.
  // ---------------------------------------------------------------------------
  // A code of seven or above selects no pin, so an unused port stays quiet.
  always_comb
  begin
    for (int p = 0; p < deir_pkg::NUM_AUDIO; p++)
    begin
      if (muteSel_reg[p] < 3'(deir_pkg::NUM_PINS))
        mutePin[p] = pinSync_reg[muteSel_reg[p]];
      else
        mutePin[p] = 1'b0;
    end
  end

  // The only way an outside pin becomes an event or interrupt is through this
  // map or the wait detector; there is no general interrupt pin.
  always_comb
  begin
    eventLine = deir_pkg::RST_WORD;
    for (int i = 0; i < 4; i++)
    begin
      eventLine[deir_pkg::EV_SW_LOW[i]] = swTrig_reg[i];
      eventLine[deir_pkg::EV_SW_HIGH[i]] = swTrig_reg[deir_pkg::SW_HIGH_BASE + i];
      eventLine[deir_pkg::EV_TIMER[i]] = link.timerRequest[i];
      eventLine[deir_pkg::EV_I2C_BASE + i] = link.i2cEvent[i];
    end
    for (int i = 0; i < 2; i++)
    begin
      eventLine[deir_pkg::EV_SW_EXTRA[i]] = swTrig_reg[deir_pkg::SW_EXTRA_BASE + i];
      eventLine[deir_pkg::EV_SPI_BASE + i] = link.spiReceiveRequest[i];
    end
    for (int i = 0; i < 6; i++)
      eventLine[deir_pkg::EV_AUDIO_REQ_BASE + i] = link.audioRequest[i];
    eventLine[deir_pkg::EV_HOST] = link.hostPortCpuEvent;
    eventLine[deir_pkg::EV_TIMER_OVF] = link.timerOverflowError;
    // Merged sources: software must sort out which one fired.
    for (int p = 0; p < deir_pkg::NUM_AUDIO; p++)
      eventLine[deir_pkg::EV_AUDIO_ERR_BASE + p] = mutePin[p] | link.audioTxInt[p] | link.audioRxInt[p];
    eventLine[deir_pkg::EV_RESERVED] = 1'b0;
  end

  // Line state register, the reference for edge detection.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      line_reg <= deir_pkg::RST_WORD;
    else
      line_reg <= eventLine;
  end

  // ---------------------------------------------------------------------------
  // Event flags.
  // ---------------------------------------------------------------------------
  // A flag sets on the chosen edge of an enabled line; a set in the same cycle
  // as a write-one-to-clear wins, so no event is lost.
  always_comb
  begin
    flags_next = flags_reg;
    if (wbWrite && wb_adr_i == deir_pkg::ADDR_FLAGS)
      flags_next = flags_next & ~wb_dat_i;
    flags_next = flags_next | (enable_reg &
      ((edgePol_reg & eventLine & ~line_reg) | (~edgePol_reg & ~eventLine & line_reg)));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      flags_reg <= deir_pkg::RST_WORD;
    else
      flags_reg <= flags_next;
  end

  // ---------------------------------------------------------------------------
  // Wishbone slave.
  // ---------------------------------------------------------------------------
  // Ack comes one cycle after the strobe and drops the next cycle.
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWrite = wbReq & wb_we_i;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wbReq;
  end

  // Configuration writes; byte lanes are ignored, so wb_sel_i never masks a write.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      edgePol_reg <= deir_pkg::RST_WORD;
      enable_reg <= deir_pkg::RST_WORD;
      hpSel_reg <= deir_pkg::RST_WORD;
      lpSel_reg <= deir_pkg::RST_WORD;
      irqSel_reg <= deir_pkg::RST_WORD;
      for (int p = 0; p < deir_pkg::NUM_AUDIO; p++)
        muteSel_reg[p] <= deir_pkg::MUTE_SEL_NONE;
      waitEn_reg <= 1'b0;
      waitPol_reg <= 1'b0;
    end
    else if (wbWrite)
    begin
      unique case (wb_adr_i)
        deir_pkg::ADDR_EDGE_POL: edgePol_reg <= wb_dat_i;
        deir_pkg::ADDR_EN_SET: enable_reg <= enable_reg | wb_dat_i;
        deir_pkg::ADDR_EN_CLR: enable_reg <= enable_reg & ~wb_dat_i;
        deir_pkg::ADDR_HP_SEL: hpSel_reg <= wb_dat_i;
        deir_pkg::ADDR_LP_SEL: lpSel_reg <= wb_dat_i;
        deir_pkg::ADDR_IRQ_SEL: irqSel_reg <= wb_dat_i;
        deir_pkg::ADDR_MUTE_SEL0: muteSel_reg[0] <= wb_dat_i[2:0];
        deir_pkg::ADDR_MUTE_SEL1: muteSel_reg[1] <= wb_dat_i[2:0];
        deir_pkg::ADDR_MUTE_SEL2: muteSel_reg[2] <= wb_dat_i[2:0];
        deir_pkg::ADDR_WAIT_CTRL:
        begin
          waitEn_reg <= wb_dat_i[deir_pkg::WAIT_EN_BIT];
          waitPol_reg <= wb_dat_i[deir_pkg::WAIT_POL_BIT];
        end
        default: ; // Read-only and unmapped words ignore writes.
      endcase
    end
  end

  // Read mux; transfer engines are absent, so their status words read zero.
  always_comb
  begin
    unique case (wb_adr_i)
      deir_pkg::ADDR_EDGE_POL: rdData = edgePol_reg;
      deir_pkg::ADDR_EN_SET: rdData = enable_reg;
      deir_pkg::ADDR_HP_SEL: rdData = hpSel_reg;
      deir_pkg::ADDR_LP_SEL: rdData = lpSel_reg;
      deir_pkg::ADDR_FLAGS: rdData = flags_reg;
      deir_pkg::ADDR_LINE0, deir_pkg::ADDR_LINE1,
      deir_pkg::ADDR_LINE2, deir_pkg::ADDR_LINE3: rdData = line_reg;
      deir_pkg::ADDR_IRQ_SEL: rdData = irqSel_reg;
      deir_pkg::ADDR_MUTE_SEL0: rdData = {29'h0000_0000, muteSel_reg[0]};
      deir_pkg::ADDR_MUTE_SEL1: rdData = {29'h0000_0000, muteSel_reg[1]};
      deir_pkg::ADDR_MUTE_SEL2: rdData = {29'h0000_0000, muteSel_reg[2]};
      deir_pkg::ADDR_WAIT_CTRL: rdData = {30'h0000_0000, waitPol_reg, waitEn_reg};
      default: rdData = deir_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wb_dat_o <= deir_pkg::RST_WORD;
    else if (wbReq && !wb_we_i)
      wb_dat_o <= rdData;
  end

  // ---------------------------------------------------------------------------
  // CPU-side trigger port.
  // ---------------------------------------------------------------------------
  // This register sits on the processor's own port, not on the bus map.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      swTrig_reg <= deir_pkg::RST_WORD;
    else if (swTriggerWrite)
      swTrig_reg <= swTriggerData;
  end

  assign swTriggerValue = swTrig_reg;
  assign swEventStatus = flags_reg;

  // Group outputs towards the two transfer engines and the interrupt entry.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      highGroupPending <= deir_pkg::RST_WORD;
      lowGroupPending <= deir_pkg::RST_WORD;
      cpuEventInterrupt <= 1'b0;
    end
    else
    begin
      highGroupPending <= flags_reg & hpSel_reg;
      lowGroupPending <= flags_reg & lpSel_reg;
      cpuEventInterrupt <= |(flags_reg & irqSel_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Wait-pin interrupt.
  // ---------------------------------------------------------------------------
  // Always a rising edge; the polarity bit only leaves the block.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      waitPrev_reg <= 1'b0;
      nmi_reg <= 1'b0;
    end
    else
    begin
      waitPrev_reg <= waitSync_reg;
      nmi_reg <= waitEn_reg & waitSync_reg & ~waitPrev_reg;
    end
  end

  assign link.nonmaskableInterruptLine = nmi_reg;
  assign waitPolarity = waitPol_reg;
endmodule // deir_device
`default_nettype wire

// file: deir_props.sv
// Concurrent checks on the routing link and on the device's bus and event outputs.
`default_nettype none
module deir_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic memoryWaitInput,
  input wire logic nonmaskableInterruptLine,
  input wire logic hostPortCpuEvent,
  input wire logic timerOverflowError,
  input wire logic [3:0] i2cEvent,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] swEventStatus,
  input wire logic cpuEventInterrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------------------
  // Helper logic.
  // ---------------------------------------------------------------------------
  logic waitPrev; // Wait pin one cycle earlier.
  logic [3:0] sinceRise; // Cycles since the last wait-pin rise, saturating at 15.
  // The pin passes through synchronisers, so the pulse is tied to the rise by age.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      waitPrev <= 1'b0;
    else
      waitPrev <= memoryWaitInput;
  end
  // Age counter; it saturates so that an old rise never aliases to a new one.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      sinceRise <= 4'hF;
    else if (memoryWaitInput && !waitPrev)
      sinceRise <= 4'h0;
    else if (sinceRise != 4'hF)
      sinceRise <= sinceRise + 4'h1;
  end
  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  a_ack_next_cycle: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_nmi_one_pulse: assert property (nonmaskableInterruptLine |=> !nonmaskableInterruptLine)
    else $error("interrupt pulse longer than one cycle");
  a_nmi_after_rise: assert property (nonmaskableInterruptLine |-> (sinceRise >= 4'h1 && sinceRise <= 4'h5))
    else $error("interrupt pulse not caused by a wait-pin rise");
  a_reserved_quiet: assert property (!swEventStatus[25])
    else $error("reserved event flag set");
  a_irq_needs_flag: assert property (cpuEventInterrupt |-> $past(swEventStatus) != 32'h0)
    else $error("cpu interrupt without any event flag");
  a_host_flag_src: assert property ($rose(swEventStatus[12]) |-> ($past(hostPortCpuEvent) != $past(hostPortCpuEvent, 2))
    || ($past(hostPortCpuEvent, 2) != $past(hostPortCpuEvent, 3)))
    else $error("host event flag without a line change");
  a_ovf_flag_src: assert property ($rose(swEventStatus[29]) |-> ($past(timerOverflowError) != $past(timerOverflowError, 2))
    || ($past(timerOverflowError, 2) != $past(timerOverflowError, 3)))
    else $error("overflow event flag without a line change");
  a_i2c_flag_src: assert property ($rose(swEventStatus[19]) |-> ($past(i2cEvent[0]) != $past(i2cEvent[0], 2))
    || ($past(i2cEvent[0], 2) != $past(i2cEvent[0], 3)))
    else $error("i2c event flag without a line change");
endmodule // deir_props
`default_nettype wire

// file: dma_event_input_routing_tb_top.sv
// Self-checking bench joining the source end and the routing device across the link.
`default_nettype none
module dma_event_input_routing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0; // 20 MHz clock.
  logic rst_n = 1'b0; // Synchronous reset, active low.
  logic [31:0] wbAdr = 32'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR, swValue, swStatus, hiPend, loPend, rdata;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbAck, cpuIrq, waitPol, nmiSeen;
  logic swWr = 1'b0;
  logic [31:0] swData = 32'h0;
  logic [23:0] srcVec = 24'h0; // Packed source levels, timer requests at the top, overflow at bit 0.
  logic [6:0] pinVec = 7'h0; // Candidate mute pins.
  logic waitPin = 1'b0; // Memory wait pin.
  int err_total = 0;
  int tests_run = 0;
  int nmiCount = 0; // Interrupt pulses seen back at the source end.
  localparam int EV_OF_SRC [24] = '{29, 26, 27, 28, 26, 27, 28, 19, 20, 21, 22, 13, 14, 12, 4, 5, 6, 7, 8, 9, 2, 3, 15, 16};
  localparam int SW_BIT [10] = '{0, 1, 2, 3, 16, 17, 18, 19, 20, 21};
  localparam int SW_EV [10] = '{0, 10, 17, 23, 1, 11, 18, 24, 30, 31};
  localparam logic [31:0] WAIT_CFG [4] = '{32'h0, 32'h1, 32'h3, 32'h2};
  localparam int NMI_EXP [4] = '{0, 1, 2, 2};
  // ---------------------------------------------------------------------------
  // Clock, design and checker.
  // ---------------------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  // Counts pulses; the source's copy is registered so sampling here is race free.
  always @(posedge ref_clk)
    if (nmiSeen === 1'b1) nmiCount++;
  deir_if linkIf ();
  deir_source deir_source_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(linkIf.source), .timerRequestIn(srcVec[23:20]),
    .audioRequestIn(srcVec[19:14]), .hostPortIn(srcVec[13]), .spiReceiveIn(srcVec[12:11]), .i2cEventIn(srcVec[10:7]),
    .audioTxIntIn(srcVec[6:4]), .audioRxIntIn(srcVec[3:1]), .timerOverflowIn(srcVec[0]), .ioPinIn(pinVec),
    .memoryWaitIn(waitPin), .nmiSeen(nmiSeen));
  deir_device deir_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(linkIf.device), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_we_i(wbWe), .wb_sel_i(4'hF), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .swTriggerWrite(swWr), .swTriggerData(swData), .swTriggerValue(swValue),
    .swEventStatus(swStatus), .highGroupPending(hiPend), .lowGroupPending(loPend), .cpuEventInterrupt(cpuIrq),
    .waitPolarity(waitPol));
  deir_props deir_props_i (.ref_clk(ref_clk), .rst_n(rst_n), .memoryWaitInput(linkIf.memoryWaitInput),
    .nonmaskableInterruptLine(linkIf.nonmaskableInterruptLine), .hostPortCpuEvent(linkIf.hostPortCpuEvent),
    .timerOverflowError(linkIf.timerOverflowError), .i2cEvent(linkIf.i2cEvent), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .swEventStatus(swStatus), .cpuEventInterrupt(cpuIrq));
  // ---------------------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high, with a bounded wait.
  task automatic bus(input logic [31:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbAdr <= a;
    wbWe <= we;
    wbDatW <= d;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    rdata = wbDatR;
    if (n >= 50)
    begin
      err_total++;
      $display("FAIL at %0t ack %h expected %h", $time, wbAck, 1'b1);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic trig(input logic [31:0] d);
    @(posedge ref_clk);
    swWr <= 1'b1;
    swData <= d;
    @(posedge ref_clk);
    swWr <= 1'b0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog: the sequence needs a few thousand cycles at most.
  initial
  begin
    #1000000;
    err_total++;
    close_out();
  end
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial
  begin
    tick(8);
    rst_n <= 1'b1;
    rd(deir_pkg::ADDR_EDGE_POL, 32'h0);
    rd(deir_pkg::ADDR_MUTE_SEL0, 32'h7);
    wr(deir_pkg::ADDR_MUTE_SEL2, 32'h6);
    rd(deir_pkg::ADDR_MUTE_SEL2, 32'h6);
    rd(deir_pkg::ADDR_WAIT_CTRL, 32'h0);
    wr(deir_pkg::ADDR_EN_SET, 32'hF0);
    wr(deir_pkg::ADDR_EN_CLR, 32'h30);
    rd(deir_pkg::ADDR_EN_SET, 32'hC0);
    rd(deir_pkg::ADDR_EN_CLR, 32'h0);
    wr(deir_pkg::ADDR_CBUF0, 32'hFFFFFFFF);
    rd(deir_pkg::ADDR_CBUF0, 32'h0);
    rd(32'h60000004, 32'h0);
    $display("test registers done");
    wr(deir_pkg::ADDR_EN_SET, 32'hFFFFFFFF);
    wr(deir_pkg::ADDR_EDGE_POL, 32'hFFFFFFFF);
    wr(deir_pkg::ADDR_HP_SEL, 32'h0000FFFF);
    wr(deir_pkg::ADDR_LP_SEL, 32'hFFFF0000);
    for (int i = 0; i < 10; i++)
    begin
      trig(32'h1 << SW_BIT[i]);
      tick(3);
      chk(swValue, 32'h1 << SW_BIT[i]);
      rd(deir_pkg::ADDR_FLAGS, 32'h1 << SW_EV[i]);
      chk(swStatus, 32'h1 << SW_EV[i]);
      rd(deir_pkg::ADDR_LINE1, 32'h1 << SW_EV[i]);
      chk(hiPend, (32'h1 << SW_EV[i]) & 32'h0000FFFF);
      chk(loPend, (32'h1 << SW_EV[i]) & 32'hFFFF0000);
      trig(32'h0);
      wr(deir_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    end
    $display("test software triggers done");
    for (int i = 0; i < 24; i++)
    begin
      srcVec <= 24'h1 << i;
      tick(4);
      rd(deir_pkg::ADDR_FLAGS, 32'h1 << EV_OF_SRC[i]);
      rd(deir_pkg::ADDR_LINE0, 32'h1 << EV_OF_SRC[i]);
      srcVec <= 24'h0;
      tick(4);
      wr(deir_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    end
    wr(deir_pkg::ADDR_EDGE_POL, 32'hFFFFFFFB);
    srcVec <= 24'h100000;
    tick(4);
    rd(deir_pkg::ADDR_FLAGS, 32'h0);
    rd(deir_pkg::ADDR_LINE2, 32'h4);
    srcVec <= 24'h0;
    tick(4);
    rd(deir_pkg::ADDR_FLAGS, 32'h4);
    rd(deir_pkg::ADDR_LINE3, 32'h0);
    wr(deir_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    wr(deir_pkg::ADDR_EDGE_POL, 32'hFFFFFFFF);
    $display("test peripheral events done");
    wr(deir_pkg::ADDR_MUTE_SEL1, 32'h3);
    wr(deir_pkg::ADDR_IRQ_SEL, 32'h08000000);
    pinVec <= 7'h10;
    tick(2);
    pinVec <= 7'h08;
    tick(2);
    pinVec <= 7'h00;
    tick(6);
    chk({31'h0, cpuIrq}, 32'h1);
    rd(deir_pkg::ADDR_FLAGS, 32'h08000000);
    wr(deir_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    tick(2);
    chk({31'h0, cpuIrq}, 32'h0);
    $display("test mute pin done");
    for (int k = 0; k < 4; k++)
    begin
      wr(deir_pkg::ADDR_WAIT_CTRL, WAIT_CFG[k]);
      waitPin <= 1'b1;
      tick(2);
      waitPin <= 1'b0;
      tick(8);
      chk(nmiCount, NMI_EXP[k]);
    end
    chk({31'h0, waitPol}, 32'h1);
    $display("test wait pin done");
    // A reset in mid-run must bring the wait interrupt back to disabled.
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rd(deir_pkg::ADDR_WAIT_CTRL, 32'h0);
    rd(deir_pkg::ADDR_MUTE_SEL2, 32'h7);
    chk({31'h0, waitPol}, 32'h0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // dma_event_input_routing_tb_top
`default_nettype wire
